// File: pll_ctrl_pkg.sv
// Package of register map, field layout, reset values and timing for the loop control block
package pll_ctrl_pkg;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] ADDR_CLOCK_DIVISOR_REGISTER = 8'h00;
    localparam logic [7:0] ADDR_FBD = 8'h04;
    localparam logic [7:0] ADDR_OSC = 8'h08;
    localparam logic [7:0] ADDR_CFG = 8'h0c;
    localparam logic [7:0] ADDR_ISTAT = 8'h10;
    localparam logic [7:0] ADDR_IMASK = 8'h14;
    // ************************************************************
    // Field positions and widths
    // ************************************************************
    localparam int PRE_LSB = 0;
    localparam int PRE_W = 5;
    localparam int POST_LSB = 6;
    localparam int POST_W = 2;
    localparam int FBD_W = 9;
    localparam int OSC_REQ_BIT = 0;
    localparam int OSC_LOCK_BIT = 5;
    localparam int OSC_NEW_LSB = 8;
    localparam int OSC_CUR_LSB = 12;
    localparam int SRC_W = 3;
    localparam int CFG_WAIT_BIT = 0;
    localparam int INT_LOCK_BIT = 0;
    localparam int INT_SW_BIT = 1;
    localparam int INT_W = 2;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [4:0] PRE_RST = 5'h00;
    localparam logic [1:0] POST_RST = 2'h1;
    localparam logic [8:0] FBD_RST = 9'h030;
    localparam logic WAIT_RST = 1'b1;
    localparam logic [5:0] N1_RST = 6'h02;
    localparam logic [9:0] M_RST = 10'h032;
    localparam logic [3:0] N2_RST = 4'h4;
    // ************************************************************
    // Source codes and bus answers
    // ************************************************************
    localparam logic [2:0] SRC_FAST_RC = 3'h0;
    localparam logic [2:0] SRC_FAST_RC_LOOP = 3'h1;
    localparam logic [2:0] SRC_PRIMARY = 3'h2;
    localparam logic [2:0] SRC_PRIMARY_LOOP = 3'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int LOCK_TIME_NS = 50000;
    localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_CNT_W = 12;
endpackage

// File: lock_timer_if.sv
// Interface between the switch controller and the lock settling timer
interface lock_timer_if;
    logic ce;
    logic start;
    logic clk_avail;
    logic done;
    modport ctrl (output ce, output start, output clk_avail, input done);
    modport timer (input ce, input start, input clk_avail, output done);
endinterface

// File: lock_timer.sv
// Lock settling timer: counts the settling interval once the loop input clock is present
module lock_timer
    import pll_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    lock_timer_if.timer tif
);
    logic [LOCK_CNT_W-1:0] cnt_r;
    logic run_r;
    logic done_r;

    assign tif.done = done_r;

    // Start restarts the interval; counting holds off until the input clock exists
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else if (tif.ce) begin
            if (tif.start) begin
                cnt_r <= '0;
                run_r <= 1'b1;
                done_r <= 1'b0;
            end else if (run_r && tif.clk_avail) begin // see R08
                if (cnt_r == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
                    run_r <= 1'b0;
                    done_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_done_needs_clk: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(done_r) |-> $past(tif.clk_avail) && $past(cnt_r) == LOCK_CNT_W'(LOCK_CYCLES - 1)) // see R08
        else $error("settling ended without input clock or early");
endmodule

// File: pll_lock_ctrl.sv
// Divider registers, clock switch sequencing and lock status for the frequency loop
// ************************************************************
// Overview of operation
// R01 - Input divide ratio is prescale field plus two
// R02 - Feedback ratio is feedback field plus two
// R03 - Output ratio is twice postscale field plus two
// R04 - Output clock follows ratios; software keeps below 80MHz
// R05 - Software keeps reference and oscillator in range
// R06 - Reset loads prescale 0, postscale 1, feedback 48
// R07 - Settling interval applied at reset and switch
// R08 - Settling starts only when input clock present
// R09 - Lock flag is read-only bit five
// R10 - Lock cleared at reset and loop switch
// R11 - Lock held low on non-loop source
// R12 - Software should poll lock after switching
// R13 - Software changes dividers only off the loop
// R14 - Odd input frequency: start without loop first
// R15 - Loop offered only to fast RC and primary
// R16 - Wait-for-lock bit delays switch until lock
// R17 - Request bit switches to new source when ready
// R18 - Lock set after interval, held while selected
// ************************************************************
module pll_lock_ctrl
    import pll_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic primary_ready,
    input wire logic [pll_ctrl_pkg::SRC_W-1:0] initial_source_select,
    output logic [5:0] input_divide_ratio,
    output logic [9:0] feedback_ratio,
    output logic [3:0] output_ratio,
    output logic [pll_ctrl_pkg::SRC_W-1:0] current_source,
    output logic loop_locked,
    output logic irq
);
    import pll_ctrl_pkg::*;

    typedef enum logic [1:0] {SW_IDLE, SW_WAIT_SRC, SW_WAIT_LOCK} sw_state_type;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r, wdata_r;
    logic [3:0] wstrb_r;
    logic [7:0] waddr_r;
    logic aw_have_r, w_have_r, wr_fire;
    logic [PRE_W-1:0] prescale_r;
    logic [POST_W-1:0] postscale_r;
    logic [FBD_W-1:0] feedback_r;
    logic [SRC_W-1:0] new_src_r, pend_src_r, cur_src_r;
    logic req_r, wait_en_r, lock_r, started_r, irq_r;
    logic [INT_W-1:0] istat_r, imask_r, int_set;
    logic [5:0] n1_r;
    logic [9:0] m_r;
    logic [3:0] n2_r;
    logic prim_meta_r, prim_sync_r;
    logic [SRC_W-1:0] strap_meta_r, strap_sync_r;
    sw_state_type sw_state_r;
    logic pend_ready, commit;
    lock_timer_if tif ();

    function automatic logic uses_loop(input logic [SRC_W-1:0] s);
        return (s == SRC_FAST_RC_LOOP) || (s == SRC_PRIMARY_LOOP); // see R15
    endfunction

    // Crystal based sources are usable only after the start-up timer expired
    function automatic logic src_ready(input logic [SRC_W-1:0] s, input logic prim);
        return ((s == SRC_PRIMARY) || (s == SRC_PRIMARY_LOOP)) ? prim : 1'b1;
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Not reset, so the strap is already valid when reset releases
    always_ff @(posedge aclk) begin
        prim_meta_r <= primary_ready;
        prim_sync_r <= prim_meta_r;
        strap_meta_r <= initial_source_select;
        strap_sync_r <= strap_meta_r;
    end

    // ************************************************************
    // AXI4-Lite write path
    // ************************************************************
    assign wr_fire = ce && aw_have_r && w_have_r && !bvalid_r;

    // Address and data are taken in either order and held until both are here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            waddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (ce) begin
            awready_r <= !aw_have_r && !(awvalid && awready_r);
            wready_r <= !w_have_r && !(wvalid && wready_r);
            if (awvalid && awready_r) begin
                aw_have_r <= 1'b1;
                waddr_r <= awaddr;
            end
            if (wvalid && wready_r) begin
                w_have_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r <= (waddr_r[7:2] <= ADDR_IMASK[7:2] && waddr_r[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read path
    // ************************************************************
    // One read at a time; data is picked in the accept cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (ce) begin
            arready_r <= !rvalid_r && !(arvalid && arready_r);
            if (arvalid && arready_r) begin
                rvalid_r <= 1'b1;
                rresp_r <= RESP_OKAY;
                rdata_r <= '0;
                unique case (araddr)
                    ADDR_CLOCK_DIVISOR_REGISTER: begin
                        rdata_r[PRE_LSB +: PRE_W] <= prescale_r;
                        rdata_r[POST_LSB +: POST_W] <= postscale_r;
                    end
                    ADDR_FBD: rdata_r[FBD_W-1:0] <= feedback_r;
                    ADDR_OSC: begin
                        rdata_r[OSC_REQ_BIT] <= req_r;
                        rdata_r[OSC_LOCK_BIT] <= lock_r; // see R09
                        rdata_r[OSC_NEW_LSB +: SRC_W] <= new_src_r;
                        rdata_r[OSC_CUR_LSB +: SRC_W] <= cur_src_r;
                    end
                    ADDR_CFG: rdata_r[CFG_WAIT_BIT] <= wait_en_r;
                    ADDR_ISTAT: rdata_r[INT_W-1:0] <= istat_r;
                    ADDR_IMASK: rdata_r[INT_W-1:0] <= imask_r;
                    default: rresp_r <= RESP_SLVERR;
                endcase
            end else if (rvalid_r && rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Divider fields
    // ************************************************************
    // Changing these while on the loop is the software's hazard, not blocked here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale_r <= PRE_RST; // see R06
            postscale_r <= POST_RST; // see R06
            feedback_r <= FBD_RST; // see R06
        end else if (wr_fire) begin
            if (waddr_r == ADDR_CLOCK_DIVISOR_REGISTER && wstrb_r[0]) begin
                prescale_r <= wdata_r[PRE_LSB +: PRE_W];
                postscale_r <= wdata_r[POST_LSB +: POST_W];
            end
            if (waddr_r == ADDR_FBD) begin
                if (wstrb_r[0]) feedback_r[7:0] <= wdata_r[7:0];
                if (wstrb_r[1]) feedback_r[8] <= wdata_r[8];
            end
        end
    end

    // Ratios handed to the analog dividers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            n1_r <= N1_RST;
            m_r <= M_RST;
            n2_r <= N2_RST;
        end else if (ce) begin
            n1_r <= 6'(prescale_r) + 6'h02; // see R01
            m_r <= 10'(feedback_r) + 10'h002; // see R02
            n2_r <= {1'b0, postscale_r, 1'b0} + 4'h2; // see R03 R04
        end
    end

    // ************************************************************
    // Control and mask registers
    // ************************************************************
    // The oscillator control word is write-protected while a switch runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            new_src_r <= SRC_FAST_RC;
            wait_en_r <= WAIT_RST;
            imask_r <= '0;
        end else if (wr_fire) begin
            if (waddr_r == ADDR_OSC && sw_state_r == SW_IDLE && wstrb_r[1]) begin
                new_src_r <= wdata_r[OSC_NEW_LSB +: SRC_W];
            end
            if (waddr_r == ADDR_CFG && wstrb_r[0]) begin
                wait_en_r <= wdata_r[CFG_WAIT_BIT];
            end
            if (waddr_r == ADDR_IMASK && wstrb_r[0]) begin
                imask_r <= wdata_r[INT_W-1:0];
            end
        end
    end

    // ************************************************************
    // Clock switch sequencer
    // ************************************************************
    assign pend_ready = src_ready(pend_src_r, prim_sync_r);
    assign commit = ce && ((sw_state_r == SW_WAIT_SRC && pend_ready && !(uses_loop(pend_src_r) && wait_en_r))
        || (sw_state_r == SW_WAIT_LOCK && tif.done));
    assign tif.ce = ce;
    assign tif.clk_avail = src_ready(sw_state_r == SW_IDLE ? cur_src_r : pend_src_r, prim_sync_r); // see R08
    // Interval restarts at power-on with a loop strap and whenever a switch heads for the loop
    assign tif.start = ce && ((!started_r && uses_loop(strap_sync_r))
        || (sw_state_r == SW_WAIT_SRC && pend_ready && uses_loop(pend_src_r))); // see R07

    // Request is taken from software, dropped by hardware once the switch is made
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_state_r <= SW_IDLE;
            req_r <= 1'b0;
            pend_src_r <= SRC_FAST_RC;
            cur_src_r <= SRC_FAST_RC;
            started_r <= 1'b0;
        end else if (ce) begin
            if (!started_r) begin
                started_r <= 1'b1;
                cur_src_r <= strap_sync_r;
            end
            unique case (sw_state_r)
                SW_IDLE: begin
                    if (req_r) begin // see R17
                        pend_src_r <= new_src_r;
                        sw_state_r <= SW_WAIT_SRC;
                    end else if (wr_fire && waddr_r == ADDR_OSC && wstrb_r[0]) begin
                        req_r <= wdata_r[OSC_REQ_BIT];
                    end
                end
                SW_WAIT_SRC: begin
                    if (pend_ready && uses_loop(pend_src_r) && wait_en_r) begin
                        sw_state_r <= SW_WAIT_LOCK; // see R16
                    end
                end
                SW_WAIT_LOCK: ;
            endcase
            if (commit) begin
                cur_src_r <= pend_src_r; // see R17
                req_r <= 1'b0;
                sw_state_r <= SW_IDLE;
            end
        end
    end

    lock_timer u_lock_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .tif(tif.timer)
    );

    // ************************************************************
    // Lock flag
    // ************************************************************
    // Cleared on a non-loop source or a fresh interval, set when the interval ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_r <= 1'b0; // see R10
        end else if (ce) begin
            if (commit && !uses_loop(pend_src_r)) begin
                lock_r <= 1'b0; // see R11
            end else if (!commit && !uses_loop(cur_src_r) && started_r) begin
                lock_r <= 1'b0; // see R11
            end else if (tif.start) begin
                lock_r <= 1'b0; // see R10
            end else if (tif.done && (sw_state_r == SW_WAIT_LOCK || uses_loop(cur_src_r) || commit)) begin
                lock_r <= 1'b1; // see R18
            end
        end
    end

    // ************************************************************
    // Interrupt status
    // ************************************************************
    // The timer's done stays high, so the lock event needs the same loop condition as the flag
    assign int_set = {commit, tif.done && !lock_r && !tif.start
        && (sw_state_r == SW_WAIT_LOCK || uses_loop(cur_src_r))};

    // A new event in the clearing cycle survives the write of one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_r <= '0;
            irq_r <= 1'b0;
        end else if (ce) begin
            if (wr_fire && waddr_r == ADDR_ISTAT && wstrb_r[0]) begin
                istat_r <= (istat_r & ~wdata_r[INT_W-1:0]) | int_set;
            end else begin
                istat_r <= istat_r | int_set;
            end
            irq_r <= |(istat_r & imask_r);
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign input_divide_ratio = n1_r;
    assign feedback_ratio = m_r;
    assign output_ratio = n2_r;
    assign current_source = cur_src_r;
    assign loop_locked = lock_r;
    assign irq = irq_r;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_loop_request;
        sw_state_r == SW_WAIT_SRC && pend_ready && uses_loop(pend_src_r) && ce;
    endsequence

    sequence s_wait_lock_entered;
        sw_state_r == SW_WAIT_LOCK && !lock_r;
    endsequence

    a_reset_values: assert property ($past(!aresetn) |-> prescale_r == PRE_RST && postscale_r == POST_RST
        && feedback_r == FBD_RST && !lock_r) // see R06
        else $error("divider fields or lock wrong after reset");
    a_ratio_calc: assert property (ce |=> n1_r == 6'($past(prescale_r)) + 6'h02
        && m_r == 10'($past(feedback_r)) + 10'h002 && n2_r == 4'({$past(postscale_r), 1'b0}) + 4'h2) // see R01
        else $error("divide ratio does not follow its field");
    a_lock_nonloop: assert property (started_r && !uses_loop(cur_src_r) |-> !lock_r) // see R11
        else $error("lock set on a non-loop source");
    a_lock_rise_cause: assert property ($rose(lock_r) |-> $past(tif.done) && uses_loop($past(pend_src_r)
        | $past(cur_src_r))) // see R18
        else $error("lock rose without settling interval");
    a_wait_then_lock: assert property (s_loop_request ##0 wait_en_r |=> s_wait_lock_entered
        ##1 (cur_src_r == $past(cur_src_r, 2))) // see R16
        else $error("switch onto loop did not wait for lock");
    a_no_wait_switch: assert property (s_loop_request ##0 !wait_en_r |=> cur_src_r == $past(pend_src_r)
        && !lock_r) // see R16
        else $error("switch without waiting was not immediate");
    a_switch_clears: assert property (s_loop_request |=> !lock_r) // see R10
        else $error("lock not cleared on switch to loop");
    a_lock_ro_write: assert property (wr_fire && waddr_r == ADDR_OSC && sw_state_r == SW_IDLE && !req_r
        && (lock_r || !tif.done) && !tif.start && (uses_loop(cur_src_r) || !started_r)
        |=> lock_r == $past(lock_r)) // see R09
        else $error("software write changed the lock flag");
    a_src_ready_first: assert property ($changed(cur_src_r) && $past(started_r) |->
        src_ready($past(pend_src_r), $past(prim_sync_r))) // see R17
        else $error("source switched before it was ready");
    a_irq_level: assert property (ce && (istat_r & imask_r) != '0 |=> irq_r)
        else $error("unmasked event did not raise interrupt");
endmodule

// File: tb_top.sv
// Self-checking testbench for the loop divider and lock control block
module tb_top
    import pll_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, primary_ready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, loop_locked, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] n1;
    logic [9:0] m;
    logic [3:0] n2;
    logic [2:0] cur;
    logic [2:0] strap = 3'h0;
    int num_errors = 0, check_count = 0, cyc;
    // Clock enable is tied high; the strap is only seen once per reset
    pll_lock_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .primary_ready(primary_ready),
        .initial_source_select(strap), .input_divide_ratio(n1), .feedback_ratio(m), .output_ratio(n2),
        .current_source(cur), .loop_locked(loop_locked), .irq(irq));
    // 50 MHz clock
    always #10 aclk = ~aclk;
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic results;
        if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Address and data offered together, each released once taken; bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        if (n >= 100) begin num_errors++; results(); end
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        rready <= 1'b0;
        if (n >= 100) begin num_errors++; results(); end
        chk("rdata", exp, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    // Bounded wait for the lock flag, then judge the settling time against the interval
    // Spent counts the cycles that already passed since the interval began
    task automatic wait_lock(input int spent);
        cyc = 0;
        while (!loop_locked && cyc < 4000) begin @(posedge aclk); cyc++; end
        if (cyc >= 4000) begin num_errors++; results(); end
        chk("lock_time", 1, cyc + spent >= LOCK_CYCLES - 5 && cyc + spent <= LOCK_CYCLES + 20);
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        chk("n1", N1_RST, n1);
        chk("m", M_RST, m);
        chk("n2", N2_RST, n2);
        chk("locked", 0, loop_locked);
        rd(ADDR_CLOCK_DIVISOR_REGISTER, 32'h40, RESP_OKAY);
        rd(ADDR_FBD, 32'h30, RESP_OKAY);
        rd(ADDR_CFG, 32'h1, RESP_OKAY);
        rd(ADDR_OSC, 32'h0, RESP_OKAY);
    endtask
    // Field extremes, then back to defaults; unmapped places refuse
    task automatic t_div;
        wr(ADDR_CLOCK_DIVISOR_REGISTER, 32'hdf, RESP_OKAY);
        wr(ADDR_FBD, 32'h1ff, RESP_OKAY);
        @(posedge aclk); // Ratio registers follow the field one cycle later
        chk("n1", 6'h21, n1);
        chk("n2", 4'h8, n2);
        chk("m", 10'h201, m);
        wr(ADDR_CLOCK_DIVISOR_REGISTER, 32'h40, RESP_OKAY);
        wr(ADDR_FBD, 32'h30, RESP_OKAY);
        rd(8'h20, 32'h0, RESP_SLVERR);
        wr(8'h20, 32'hffff_ffff, RESP_SLVERR);
        wr(ADDR_OSC, 32'h20, RESP_OKAY);
        rd(ADDR_OSC, 32'h0, RESP_OKAY);
    endtask
    // Fast RC with loop, waiting for lock; lock event raises the interrupt, a status write clears it
    task automatic t_loop;
        wr(ADDR_IMASK, 32'h1, RESP_OKAY);
        wr(ADDR_OSC, 32'h101, RESP_OKAY);
        wait_lock(0);
        chk("cur", 3'h1, cur);
        rd(ADDR_OSC, 32'h1120, RESP_OKAY);
        chk("irq", 1, irq);
        wr(ADDR_ISTAT, 32'h3, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("irq", 0, irq);
    endtask
    // Non-loop source drops lock; primary loop waits for the start-up timer
    task automatic t_primary;
        wr(ADDR_OSC, 32'h1, RESP_OKAY);
        repeat (10) @(posedge aclk);
        chk("locked", 0, loop_locked);
        chk("cur", 3'h0, cur);
        wr(ADDR_OSC, 32'h301, RESP_OKAY);
        repeat (3000) @(posedge aclk);
        chk("locked", 0, loop_locked);
        chk("cur", 3'h0, cur);
        primary_ready <= 1'b1;
        wait_lock(0);
        chk("cur", 3'h3, cur);
    endtask
    // Wait disabled: the loop source is taken at once and lock follows later
    task automatic t_nowait;
        wr(ADDR_OSC, 32'h1, RESP_OKAY);
        repeat (10) @(posedge aclk);
        wr(ADDR_CFG, 32'h0, RESP_OKAY);
        wr(ADDR_OSC, 32'h101, RESP_OKAY);
        repeat (10) @(posedge aclk);
        chk("cur", 3'h1, cur);
        chk("locked", 0, loop_locked);
        wr(ADDR_OSC, 32'h120, RESP_OKAY);
        chk("locked", 0, loop_locked);
        wait_lock(14);
    endtask
    // Power-on with a loop strap: the interval runs with no software request
    task automatic t_por;
        strap <= 3'h1;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        wait_lock(0);
        chk("cur", 3'h1, cur);
        chk("n1", N1_RST, n1);
    endtask
    // Main sequence: reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_div();
        t_loop();
        t_primary();
        t_nowait();
        t_por();
        results();
    end
endmodule
